// ===== strap_board_model.sv
// board strap levels and management controller model
`timescale 1ns/1ps
module strap_board_model (
	// clock
	input wire logic sys_clk,
	// strap levels: fiber, copper, top, mid, low pairs
	output logic [9:0] four_lvl,
	output logic [1:0] duplex_lvl,
	output logic [1:0] speed_lvl,
	// management
	output logic [4:0] mgmt_addr,
	output logic mgmt_wr_en,
	output logic [15:0] mgmt_wdata,
	input wire logic [15:0] mgmt_rd_data
);
	initial
	begin
		four_lvl = 10'h000;
		duplex_lvl = 2'h0;
		speed_lvl = 2'h0;
		mgmt_addr = 5'h00;
		mgmt_wr_en = 1'b0;
		mgmt_wdata = 16'h0000;
	end

	// code 3 on the three-level pins is a floating pin
	task set_straps(input logic [1:0] l, input logic [1:0] d, input logic [1:0] s);
		@(negedge sys_clk);
		four_lvl = {l + 2'h3, l, l + 2'h2, l + 2'h1, l};
		duplex_lvl = d;
		speed_lvl = s;
	endtask : set_straps

	// data inverted after the strobe so a stale word is never mistaken for a new one
	task mgmt_write(input logic [4:0] a, input logic [15:0] d);
		@(negedge sys_clk);
		mgmt_addr = a;
		mgmt_wdata = d;
		mgmt_wr_en = 1'b1;
		@(negedge sys_clk);
		mgmt_wr_en = 1'b0;
		mgmt_wdata = ~d;
	endtask : mgmt_write

	task mgmt_read(input logic [4:0] a, output logic [15:0] d);
		@(negedge sys_clk);
		mgmt_addr = a;
		@(negedge sys_clk);
		d = mgmt_rd_data;
	endtask : mgmt_read
endmodule : strap_board_model

// ===== strap_config_decoder.sv
// power-up strap decoder loading mode configuration register 30
`timescale 1ns/1ps
`include "strap_defs.svh"
module strap_config_decoder (
	// clock and reset
	input logic sys_clk,
	input logic rstn,
	// quantized strap levels
	input logic [1:0] addr_low_pair_strap,
	input logic [1:0] addr_mid_pair_strap,
	input logic [1:0] addr_top_warn_strap,
	input logic [1:0] copper_port_strap,
	input logic [1:0] fiber_port_strap,
	input logic [1:0] duplex_strap,
	input logic [1:0] speed_strap,
	// management register port
	input logic [4:0] mgmt_addr,
	input logic mgmt_wr_en,
	input logic [15:0] mgmt_wdata,
	output logic [15:0] mgmt_rd_data,
	// decoded results
	output logic strap_done,
	output logic [4:0] phy_addr,
	output logic link_integrity_warning,
	output logic [15:0] mode_cfg,
	output logic scrambler_en,
	output logic eq_bypass,
	output logic sd_threshold_high,
	output strap_pkg::op_mode_t op_mode
);
	localparam logic [7:0] LAST_CNT = 8'(`STRAP_DELAY_CYCLES - 1);

	strap_pkg::load_state_t state_reg;
	strap_pkg::load_state_t state_next;
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;
	logic [15:0] cfg_reg;
	logic [15:0] cfg_next;
	logic [15:0] rd_reg;
	logic [4:0] addr_reg;
	logic warn_reg;
	logic scr_reg;
	logic eqb_reg;
	logic sdh_reg;
	strap_pkg::op_mode_t mode_reg;
	strap_pkg::op_mode_t mode_next;

	strap_lvl_if lo_if ();
	strap_lvl_if mid_if ();
	strap_lvl_if top_if ();

	assign lo_if.code = addr_low_pair_strap;
	assign mid_if.code = addr_mid_pair_strap;
	assign top_if.code = addr_top_warn_strap;

	strap_level_decode #(.HI_FIRST(1)) u_lo (.lvl(lo_if.dec));
	strap_level_decode #(.HI_FIRST(1)) u_mid (.lvl(mid_if.dec));
	strap_level_decode #(.HI_FIRST(1)) u_top (.lvl(top_if.dec));

	// purely combinational strap decode
	wire sample = (state_reg == strap_pkg::ST_WAIT) && (cnt_reg == LAST_CNT);
	wire [4:0] addr_dec = {top_if.bits[0], mid_if.bits, lo_if.bits};
	wire cu_third = copper_port_strap == strap_pkg::LVL_THIRD;
	wire cu_two = copper_port_strap == strap_pkg::LVL_TWO_THIRDS;
	wire cu_vcc = copper_port_strap == strap_pkg::LVL_VCC;
	wire fo_third = fiber_port_strap == strap_pkg::LVL_THIRD;
	wire fo_two = fiber_port_strap == strap_pkg::LVL_TWO_THIRDS;
	wire fo_vcc = fiber_port_strap == strap_pkg::LVL_VCC;
	// open pin floats to mid supply, so open and mid decode alike
	wire dup_gnd = duplex_strap == strap_pkg::LVL3_GND;
	wire dup_vcc = duplex_strap == strap_pkg::LVL3_VCC;
	wire spd_gnd = speed_strap == strap_pkg::LVL3_GND;
	wire spd_vcc = speed_strap == strap_pkg::LVL3_VCC;
	wire mgmt_hit = mgmt_addr == `MODE_CFG_ADDR;
	wire mgmt_write = mgmt_wr_en && mgmt_hit && (state_reg == strap_pkg::ST_DONE);

	logic [15:0] strap_cfg;
	always_comb
	begin
		strap_cfg = `MODE_CFG_RESET;
		strap_cfg[`CFG_CU_PORT_BIT] = cu_third;
		strap_cfg[`CFG_SHORT_CU_BIT] = cu_two || cu_vcc;
		strap_cfg[`CFG_LOW_DRIVE_BIT] = cu_two;
		strap_cfg[`CFG_FO_PORT_BIT] = fo_third;
		strap_cfg[`CFG_SHORT_FO_BIT] = fo_vcc;
		strap_cfg[`CFG_LONG_WL_BIT] = fo_two;
		strap_cfg[`CFG_PASSTHRU_N_BIT] = dup_gnd || dup_vcc;
		strap_cfg[`CFG_FD_ADV_N_BIT] = dup_gnd;
		strap_cfg[`CFG_HD_ADV_N_BIT] = 1'b0;
		strap_cfg[`CFG_AN_DIS_BIT] = spd_gnd || spd_vcc;
		strap_cfg[`CFG_ONE_RATE_BIT] = spd_gnd || spd_vcc;
		strap_cfg[`CFG_LOW_RATE_BIT] = spd_gnd;
	end

	always_comb
	begin
		if (spd_gnd)
			mode_next = strap_pkg::MODE_FORCED_10;
		else if (spd_vcc)
			mode_next = strap_pkg::MODE_FORCED_100;
		else if (dup_gnd)
			mode_next = strap_pkg::MODE_HALF_ONLY;
		else if (dup_vcc)
			mode_next = strap_pkg::MODE_NON_TRANSP;
		else
			mode_next = strap_pkg::MODE_TRANSPARENT;
	end

	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		cfg_next = cfg_reg;
		case (state_reg)
			strap_pkg::ST_WAIT:
			begin
				cnt_next = cnt_reg + 8'h01;
				if (sample)
				begin
					state_next = strap_pkg::ST_DONE;
					cfg_next = strap_cfg;
				end
			end
			strap_pkg::ST_DONE:
			begin
				// whole word writable, fiber tuning bits included
				if (mgmt_write)
					cfg_next = mgmt_wdata;
			end
			default:
				state_next = strap_pkg::ST_WAIT;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_reg <= strap_pkg::ST_WAIT;
			cnt_reg <= 8'h00;
			cfg_reg <= `MODE_CFG_RESET;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			cfg_reg <= cfg_next;
		end
	end

	// latched strap results, taken only once
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			addr_reg <= 5'h00;
			warn_reg <= 1'b0;
			mode_reg <= strap_pkg::MODE_FORCED_10;
		end
		else if (sample)
		begin
			addr_reg <= addr_dec;
			warn_reg <= top_if.warn;
			mode_reg <= mode_next;
		end
	end

	// datapath controls follow the live register, so writes take effect
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			scr_reg <= 1'b0;
			eqb_reg <= 1'b0;
			sdh_reg <= 1'b0;
			rd_reg <= 16'h0000;
		end
		else
		begin
			scr_reg <= !cfg_reg[`CFG_CU_PORT_BIT] && !cfg_reg[`CFG_SCRAMBLE_OFF_BIT];
			eqb_reg <= !cfg_reg[`CFG_CU_PORT_BIT] && cfg_reg[`CFG_SHORT_CU_BIT] &&
				!cfg_reg[`CFG_LOW_DRIVE_BIT];
			sdh_reg <= !cfg_reg[`CFG_FO_PORT_BIT] && cfg_reg[`CFG_SHORT_FO_BIT];
			rd_reg <= mgmt_hit ? cfg_reg : 16'h0000;
		end
	end

	assign strap_done = state_reg == strap_pkg::ST_DONE;
	assign phy_addr = addr_reg;
	assign link_integrity_warning = warn_reg;
	assign mode_cfg = cfg_reg;
	assign scrambler_en = scr_reg;
	assign eq_bypass = eqb_reg;
	assign sd_threshold_high = sdh_reg;
	assign op_mode = mode_reg;
	assign mgmt_rd_data = rd_reg;

	property p_addr_low;
		@(posedge sys_clk) disable iff (!rstn)
		$rose(strap_done) && $past(addr_low_pair_strap) == 2'h1 |-> phy_addr[1:0] == 2'h2;
	endproperty
	a_addr_low: assert property (p_addr_low) else $error("third level low pair wrong");

	property p_warn;
		@(posedge sys_clk) disable iff (!rstn)
		$rose(strap_done) |-> link_integrity_warning == ($past(addr_top_warn_strap) == 2'h1 ||
			$past(addr_top_warn_strap) == 2'h2) && phy_addr[4] == $past(addr_top_warn_strap[1]);
	endproperty
	a_warn: assert property (p_warn) else $error("top strap decode wrong");

	property p_copper;
		@(posedge sys_clk) disable iff (!rstn)
		$rose(strap_done) |-> mode_cfg[3] == ($past(copper_port_strap) == 2'h1) &&
			mode_cfg[2] == $past(copper_port_strap[1]) &&
			mode_cfg[4] == ($past(copper_port_strap) == 2'h2);
	endproperty
	a_copper: assert property (p_copper) else $error("copper defaults wrong");

	property p_scramble;
		@(posedge sys_clk) disable iff (!rstn)
		strap_done && !mode_cfg[3] && !mode_cfg[12] ##1 !mode_cfg[3] && !mode_cfg[12]
			|-> scrambler_en;
	endproperty
	a_scramble: assert property (p_scramble) else $error("scrambler not enabled");

	property p_eq;
		@(posedge sys_clk) disable iff (!rstn)
		$rose(strap_done) && $past(copper_port_strap) == 2'h3 |-> ##1 eq_bypass;
	endproperty
	a_eq: assert property (p_eq) else $error("equalizer not bypassed");

	property p_fiber;
		@(posedge sys_clk) disable iff (!rstn)
		$rose(strap_done) |-> mode_cfg[7:5] == {$past(fiber_port_strap) == 2'h1,
			$past(fiber_port_strap) == 2'h2, $past(fiber_port_strap) == 2'h3};
	endproperty
	a_fiber: assert property (p_fiber) else $error("fiber defaults wrong");

	property p_sd;
		@(posedge sys_clk) disable iff (!rstn)
		$rose(strap_done) && $past(fiber_port_strap) == 2'h3 |-> ##1 sd_threshold_high;
	endproperty
	a_sd: assert property (p_sd) else $error("signal detect not raised");

	property p_duplex_open;
		@(posedge sys_clk) disable iff (!rstn)
		$rose(strap_done) && $past(duplex_strap) == 2'h3 && $past(speed_strap) == 2'h3
			|-> mode_cfg[15:8] == 8'h00 && op_mode == strap_pkg::MODE_TRANSPARENT;
	endproperty
	a_duplex_open: assert property (p_duplex_open) else $error("open strap not mid");

	property p_speed;
		@(posedge sys_clk) disable iff (!rstn)
		$rose(strap_done) && $past(speed_strap) == 2'h0 |-> mode_cfg[14] && mode_cfg[9] &&
			mode_cfg[8] && op_mode == strap_pkg::MODE_FORCED_10;
	endproperty
	a_speed: assert property (p_speed) else $error("speed gnd defaults wrong");

	property p_write;
		@(posedge sys_clk) disable iff (!rstn)
		strap_done && mgmt_wr_en && mgmt_addr == 5'h1e |=> mode_cfg == $past(mgmt_wdata);
	endproperty
	a_write: assert property (p_write) else $error("management write lost");

	property p_once;
		@(posedge sys_clk) disable iff (!rstn)
		$rose(strap_done) |-> $past(cnt_reg) == LAST_CNT ##1 strap_done [*8];
	endproperty
	a_once: assert property (p_once) else $error("sampling time or latch wrong");
endmodule : strap_config_decoder

// ===== strap_defs.svh
// offsets, field positions, reset values and timing counts for the strap decoder
`ifndef STRAP_DEFS_SVH
`define STRAP_DEFS_SVH

`define MODE_CFG_ADDR 5'h1e
`define MODE_CFG_RESET 16'h0000

`define CFG_SHORT_CU_BIT 2
`define CFG_CU_PORT_BIT 3
`define CFG_LOW_DRIVE_BIT 4
`define CFG_SHORT_FO_BIT 5
`define CFG_LONG_WL_BIT 6
`define CFG_FO_PORT_BIT 7
`define CFG_LOW_RATE_BIT 8
`define CFG_ONE_RATE_BIT 9
`define CFG_FD_ADV_N_BIT 10
`define CFG_PASSTHRU_N_BIT 11
`define CFG_SCRAMBLE_OFF_BIT 12
`define CFG_AN_DIS_BIT 14
`define CFG_HD_ADV_N_BIT 15

`define CLK_PERIOD_NS 20
`define STRAP_DELAY_NS 3000
`define STRAP_DELAY_CYCLES ((`STRAP_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== strap_level_decode.sv
// four-level strap to address pair and warning flag decode
`timescale 1ns/1ps
module strap_level_decode #(
	parameter int HI_FIRST = 1
) (
	// level in, decoded bits out
	strap_lvl_if.dec lvl
);
	wire [1:0] pair;

	// gnd 00, third 10, two-thirds 11, vcc 01 as {hi,lo}
	assign pair = (lvl.code == strap_pkg::LVL_GND) ? 2'h0 :
		(lvl.code == strap_pkg::LVL_THIRD) ? 2'h2 :
		(lvl.code == strap_pkg::LVL_TWO_THIRDS) ? 2'h3 : 2'h1;
	assign lvl.bits = (HI_FIRST != 0) ? pair : {pair[0], pair[1]};
	// only the two middle levels switch the warning on
	assign lvl.warn = (lvl.code == strap_pkg::LVL_THIRD) ||
		(lvl.code == strap_pkg::LVL_TWO_THIRDS);
endmodule : strap_level_decode

// ===== strap_lvl_if.sv
// carrier between the top and one four-level strap decoder
`timescale 1ns/1ps
interface strap_lvl_if;
	logic [1:0] code;
	logic [1:0] bits;
	logic warn;
	modport dec (input code, output bits, output warn);
	modport user (output code, input bits, input warn);
endinterface : strap_lvl_if

// ===== strap_pkg.sv
// types shared by the strap decoder modules
package strap_pkg;
	typedef enum logic [1:0] {LVL_GND, LVL_THIRD, LVL_TWO_THIRDS, LVL_VCC} four_lvl_t;
	typedef enum logic [1:0] {LVL3_GND, LVL3_MID, LVL3_VCC, LVL3_OPEN} three_lvl_t;
	typedef enum logic [2:0] {MODE_FORCED_10, MODE_FORCED_100, MODE_HALF_ONLY, MODE_NON_TRANSP,
		MODE_TRANSPARENT} op_mode_t;
	typedef enum logic {ST_WAIT, ST_DONE} load_state_t;
endpackage : strap_pkg

// ===== tb_top.sv
// self-checking bench for the strap decoder
`timescale 1ns/1ps
module tb_top;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic [9:0] four_lvl;
	logic [1:0] duplex_lvl, speed_lvl;
	logic [4:0] mgmt_addr, phy_addr;
	logic mgmt_wr_en, strap_done, link_integrity_warning;
	logic scrambler_en, eq_bypass, sd_threshold_high;
	logic [15:0] mgmt_wdata, mgmt_rd_data, mode_cfg, rd;
	strap_pkg::op_mode_t op_mode;
	int fail_count = 0;
	int num_checks = 0;
	int n;

	always #10 sys_clk = ~sys_clk;

	strap_board_model i_board (.sys_clk(sys_clk), .four_lvl(four_lvl),
		.duplex_lvl(duplex_lvl), .speed_lvl(speed_lvl), .mgmt_addr(mgmt_addr),
		.mgmt_wr_en(mgmt_wr_en), .mgmt_wdata(mgmt_wdata), .mgmt_rd_data(mgmt_rd_data));

	strap_config_decoder i_dut (.sys_clk(sys_clk), .rstn(rstn),
		.addr_low_pair_strap(four_lvl[1:0]), .addr_mid_pair_strap(four_lvl[3:2]),
		.addr_top_warn_strap(four_lvl[5:4]), .copper_port_strap(four_lvl[7:6]),
		.fiber_port_strap(four_lvl[9:8]), .duplex_strap(duplex_lvl), .speed_strap(speed_lvl),
		.mgmt_addr(mgmt_addr), .mgmt_wr_en(mgmt_wr_en), .mgmt_wdata(mgmt_wdata),
		.mgmt_rd_data(mgmt_rd_data), .strap_done(strap_done), .phy_addr(phy_addr),
		.link_integrity_warning(link_integrity_warning), .mode_cfg(mode_cfg),
		.scrambler_en(scrambler_en), .eq_bypass(eq_bypass),
		.sd_threshold_high(sd_threshold_high), .op_mode(op_mode));

	task summarize;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : summarize

	task chk(input logic [15:0] got, input logic [15:0] want, input string what);
		num_checks++;
		if (got !== want)
		begin
			fail_count++;
			$display("[FAIL] %0t %s got %h want %h", $time, what, got, want);
		end
	endtask : chk

	function automatic logic [1:0] pr(input logic [1:0] l);
		return {l[1] ^ l[0], l[1]};
	endfunction : pr

	function automatic logic [15:0] cfg_exp(input logic [1:0] c, input logic [1:0] d,
		input logic [1:0] s);
		logic [1:0] f;
		logic [15:0] v;
		f = c + 2'h3;
		v = 16'h0000;
		v[2] = c[1];
		v[3] = c == 2'h1;
		v[4] = c == 2'h2;
		v[5] = f == 2'h3;
		v[6] = f == 2'h2;
		v[7] = f == 2'h1;
		v[11] = d == 2'h0 || d == 2'h2;
		v[10] = d == 2'h0;
		v[14] = s == 2'h0 || s == 2'h2;
		v[9] = v[14];
		v[8] = s == 2'h0;
		return v;
	endfunction : cfg_exp

	task run_case(input logic [1:0] l, input logic [1:0] d, input logic [1:0] s);
		logic [15:0] e;
		logic [1:0] t;
		strap_pkg::op_mode_t m;
		i_board.set_straps(l, d, s);
		rstn = 1'b0;
		@(negedge sys_clk);
		chk({mode_cfg[15:1], strap_done}, 16'h0000, "state in reset");
		chk({phy_addr, link_integrity_warning, scrambler_en, eq_bypass, sd_threshold_high,
			op_mode, 4'h0}, 16'h0000, "outputs in reset");
		rstn = 1'b1;
		i_board.mgmt_write(5'h1e, 16'hffff);
		chk(mode_cfg, 16'h0000, "write before sampling");
		n = 2;
		while (strap_done !== 1'b1 && n < 400)
		begin
			@(negedge sys_clk);
			n++;
		end
		chk(16'(n), 16'h0096, "sampling edge");
		if (n >= 400)
			summarize();
		e = cfg_exp(l, d, s);
		t = l + 2'h2;
		chk(mode_cfg, e, "strap defaults");
		chk({11'h0, phy_addr}, {11'h0, t[1], pr(l + 2'h1), pr(l)}, "address");
		chk({15'h0, link_integrity_warning}, {15'h0, t[0] ^ t[1]}, "warning");
		m = s == 2'h0 ? strap_pkg::MODE_FORCED_10 : s == 2'h2 ? strap_pkg::MODE_FORCED_100 :
			d == 2'h0 ? strap_pkg::MODE_HALF_ONLY : d == 2'h2 ? strap_pkg::MODE_NON_TRANSP :
			strap_pkg::MODE_TRANSPARENT;
		chk({13'h0, op_mode}, {13'h0, m}, "mode");
		i_board.set_straps(~l, ~d, ~s);
		@(negedge sys_clk);
		chk(mode_cfg, e, "latched");
		chk({13'h0, scrambler_en, eq_bypass, sd_threshold_high},
			{13'h0, ~e[3], ~e[3] & e[2] & ~e[4], ~e[7] & e[5]}, "controls");
		$display("case %0d %0d %0d done", l, d, s);
	endtask : run_case

	initial
	begin
		repeat (2) @(negedge sys_clk);
		run_case(2'h0, 2'h0, 2'h0);
		run_case(2'h1, 2'h1, 2'h1);
		run_case(2'h2, 2'h2, 2'h2);
		run_case(2'h3, 2'h3, 2'h3);
		run_case(2'h1, 2'h0, 2'h1);
		run_case(2'h2, 2'h2, 2'h3);
		i_board.mgmt_write(5'h1e, 16'h1024);
		chk(mode_cfg, 16'h1024, "write");
		@(negedge sys_clk);
		chk({13'h0, scrambler_en, eq_bypass, sd_threshold_high}, 16'h0003, "ctl");
		i_board.mgmt_write(5'h1e, 16'h00e0);
		i_board.mgmt_write(5'h1d, 16'hffff);
		chk(mode_cfg, 16'h00e0, "unmapped write");
		i_board.mgmt_read(5'h1e, rd);
		chk(rd, 16'h00e0, "read back");
		i_board.mgmt_read(5'h1d, rd);
		chk(rd, 16'h0000, "unmapped read");
		$display("management test done");
		summarize();
	end
endmodule : tb_top
